//--- core/pme_pkg.sv
// Package with constants and types for program mode entry control
package pme_pkg;
  localparam logic       FUSE_DEBUG_ON      = 1'b0;
  localparam logic       FUSE_SSP_ERASED    = 1'b1;
  localparam logic       FUSE_DEBUG_ERASED  = 1'b1;
  localparam int         DBG_STACK_LEVELS   = 2;
  localparam int         DBG_PROG_BYTES     = 512;
  localparam int         DBG_DATA_BYTES     = 10;
  localparam logic [4:0] STACK_DEPTH        = 5'h1F;
  localparam logic [4:0] STACK_USER_DBG     = 5'(31 - DBG_STACK_LEVELS);
  localparam int         PROG_ADDR_W        = 14;
  localparam logic [13:0] PROG_BYTES_TOTAL  = 14'h3FFF;
  localparam logic [13:0] PROG_USER_DBG     = 14'(16383 - DBG_PROG_BYTES);
  localparam logic [9:0] DATA_TOP           = 10'h2FF;
  localparam logic [9:0] DATA_USER_DBG      = 10'(767 - DBG_DATA_BYTES);
  localparam int         SYNC_STAGES        = 2;

  typedef enum logic [2:0] {
    PME_RUN      = 3'h0,
    PME_SSP_PROG = 3'h1,
    PME_HV_PROG  = 3'h2,
    PME_DEBUG    = 3'h3
  } pme_mode_t;

  typedef enum logic [1:0] {
    ERASE_NONE  = 2'h0,
    ERASE_BLOCK = 2'h1,
    ERASE_ROW   = 2'h2
  } pme_erase_t;

  typedef struct packed {
    logic debug_fuse;
    logic ssp_fuse;
    logic code_protect;
  } pme_fuse_t;

  typedef struct packed {
    logic        reserve_mon_pins;
    logic [4:0]  stack_limit;
    logic [13:0] prog_limit;
    logic [9:0]  data_limit;
  } pme_limits_t;
endpackage

//--- core/pme_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/10ps
module pme_sync
  import pme_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  logic meta_ff;
  logic q_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= 1'b0;
      q_ff    <= 1'b0;
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule

//--- core/pme_entry_ctrl.sv
// Program mode entry, debug resource reservation and pin ownership control
`timescale 1ns/10ps
module pme_entry_ctrl
  import pme_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        clk_link,
  input  wire logic        prog_entry_pin,
  input  wire logic        master_clear_pin,
  input  wire logic        high_entry_voltage,
  input  wire logic        fuse_valid,
  input  wire logic        fuse_blank,
  input  wire pme_fuse_t   fuse_in,
  input  wire logic        fuse_ssp_wr,
  input  wire logic        fuse_ssp_wdata,
  input  wire logic        erase_req,
  input  wire pme_erase_t  erase_kind,
  input  wire logic        monitor_pin_first,
  input  wire logic        monitor_pin_second_in,
  input  wire logic        mon_data_out,
  input  wire logic        mon_data_oe,
  output logic             monitor_pin_second_out,
  output logic             monitor_pin_second_oe,
  output pme_mode_t        mode,
  output logic             core_hold,
  output logic             shared_io_pin_free,
  output pme_limits_t      limits,
  output logic             single_supply_prog_enable,
  output logic             debug_enable,
  output logic             erase_go,
  output logic             erase_reject,
  output logic             fuse_wr_reject,
  output logic             link_bit_valid,
  output logic             link_bit
);
  // Programming modes hold the core and open erase
  function automatic logic is_prog(input pme_mode_t m);
    is_prog = (m == PME_HV_PROG) | (m == PME_SSP_PROG);
  endfunction

  // Pin synchronisers on the system clock
  logic entry_s;
  logic master_clear_pin_s;
  logic hv_s;

  pme_sync u_sync_entry (
    .clk (clk_sys),
    .rst (rst),
    .d   (prog_entry_pin),
    .q   (entry_s)
  );

  pme_sync u_sync_master_clear_pin (
    .clk (clk_sys),
    .rst (rst),
    .d   (master_clear_pin),
    .q   (master_clear_pin_s)
  );

  pme_sync u_sync_hv (
    .clk (clk_sys),
    .rst (rst),
    .d   (high_entry_voltage),
    .q   (hv_s)
  );

  // Fuse shadow; loaded once fuses are valid
  logic      ssp_fuse_ff;
  logic      dbg_fuse_ff;
  logic      cp_ff;
  logic      loaded_ff;
  logic      nxt_ssp_fuse;
  pme_mode_t mode_ff;
  pme_mode_t nxt_mode;

  wire load_now   = fuse_valid & ~loaded_ff;
  wire ssp_from_f = fuse_blank ? FUSE_SSP_ERASED : fuse_in.ssp_fuse;
  wire dbg_from_f = fuse_blank ? FUSE_DEBUG_ERASED : fuse_in.debug_fuse;
  wire in_hv      = (mode_ff == PME_HV_PROG);
  wire fuse_ok    = fuse_ssp_wr & in_hv;

  always_comb begin
    nxt_ssp_fuse = ssp_fuse_ff;
    if (load_now) begin
      nxt_ssp_fuse = ssp_from_f;
    end else if (fuse_ok) begin
      nxt_ssp_fuse = fuse_ssp_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ssp_fuse_ff <= FUSE_SSP_ERASED;
      dbg_fuse_ff <= FUSE_DEBUG_ERASED;
      cp_ff       <= 1'b0;
      loaded_ff   <= 1'b0;
    end else begin
      ssp_fuse_ff <= nxt_ssp_fuse;
      loaded_ff   <= loaded_ff | fuse_valid;
      if (load_now) begin
        dbg_fuse_ff <= dbg_from_f;
        cp_ff       <= fuse_blank ? 1'b0 : fuse_in.code_protect;
      end
    end
  end

  // Entry decode; high voltage outranks every other entry once fuses are loaded
  wire dbg_on    = (dbg_fuse_ff == FUSE_DEBUG_ON);
  wire hv_entry  = hv_s;
  wire ssp_entry = ssp_fuse_ff & master_clear_pin_s & entry_s;
  wire run_ok    = master_clear_pin_s;

  always_comb begin
    nxt_mode = mode_ff;
    if (!loaded_ff) begin
      nxt_mode = PME_RUN;
    end else if (hv_entry) begin
      nxt_mode = PME_HV_PROG;
    end else if (ssp_entry) begin
      nxt_mode = PME_SSP_PROG;
    end else if (dbg_on) begin
      nxt_mode = PME_DEBUG;
    end else begin
      nxt_mode = PME_RUN;
    end
  end

  // Resource limits; debug carves the top of each memory
  pme_limits_t nxt_limits;
  always_comb begin
    nxt_limits.reserve_mon_pins = dbg_on;
    nxt_limits.stack_limit      = dbg_on ? STACK_USER_DBG : STACK_DEPTH;
    nxt_limits.prog_limit       = dbg_on ? PROG_USER_DBG : PROG_BYTES_TOTAL;
    nxt_limits.data_limit       = dbg_on ? DATA_USER_DBG : DATA_TOP;
  end

  // Erase checks: protected memory refuses row erase
  wire erase_ok  = erase_req & (erase_kind == ERASE_BLOCK |
                   (erase_kind == ERASE_ROW & ~cp_ff));
  wire erase_bad = erase_req & ~erase_ok;
  // Erase judged on the mode in force now, not the one coming
  wire in_prog   = is_prog(mode_ff);
  wire prog_mode = is_prog(nxt_mode);

  logic        core_hold_ff;
  logic        io_free_ff;
  logic        ssp_en_ff;
  logic        dbg_en_ff;
  logic        erase_go_ff;
  logic        erase_rej_ff;
  logic        fuse_rej_ff;
  pme_limits_t limits_ff;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_ff      <= PME_RUN;
      core_hold_ff <= 1'b1;
      io_free_ff   <= 1'b0;
      ssp_en_ff    <= 1'b0;
      dbg_en_ff    <= 1'b0;
      limits_ff    <= '0;
    end else begin
      mode_ff      <= nxt_mode;
      core_hold_ff <= ~loaded_ff | prog_mode | ~run_ok;
      // Fuse shadow resets to one, so no pin is freed before the load
      io_free_ff   <= ~nxt_ssp_fuse;
      ssp_en_ff    <= nxt_ssp_fuse;
      dbg_en_ff    <= loaded_ff & dbg_on;
      limits_ff    <= loaded_ff ? nxt_limits : '0;
    end
  end

  // One-cycle answers to erase and fuse write requests
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      erase_go_ff  <= 1'b0;
      erase_rej_ff <= 1'b0;
      fuse_rej_ff  <= 1'b0;
    end else begin
      erase_go_ff  <= erase_ok & in_prog;
      erase_rej_ff <= erase_bad | (erase_req & ~in_prog);
      fuse_rej_ff  <= fuse_ssp_wr & ~in_hv;
    end
  end

  // Registered so the link domain never sees a decode glitch
  logic link_on_ff;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      link_on_ff <= 1'b0;
    end else begin
      link_on_ff <= (loaded_ff & dbg_on) | prog_mode;
    end
  end

  // Link side: clock is the first monitor pin's own clock domain
  // Link enable (debug or either programming mode) crosses in as a level through two flops
  // Link clock stops between frames: reset and enable settle only
  // after two link edges, so a pod opens each frame with two of them
  logic dbg_l_meta_ff;
  logic dbg_l_ff;
  logic rst_l_meta_ff;
  logic rst_l_ff;
  logic mon_in_ff;
  logic mon_tog_ff;
  logic mon_out_ff;
  logic mon_oe_ff;

  always_ff @(posedge clk_link) begin
    rst_l_meta_ff <= rst;
    rst_l_ff      <= rst_l_meta_ff;
    dbg_l_meta_ff <= link_on_ff;
    dbg_l_ff      <= dbg_l_meta_ff;
  end

  // Data sampled on the link clock; toggle marks each bit
  always_ff @(posedge clk_link) begin
    if (rst_l_ff) begin
      mon_in_ff  <= 1'b0;
      mon_tog_ff <= 1'b0;
      mon_out_ff <= 1'b0;
      mon_oe_ff  <= 1'b0;
    end else begin
      mon_out_ff <= mon_data_out;
      mon_oe_ff  <= dbg_l_ff & mon_data_oe;
      if (dbg_l_ff) begin
        mon_in_ff  <= monitor_pin_second_in;
        mon_tog_ff <= ~mon_tog_ff;
      end
    end
  end

  // Toggle and data return to the system clock
  logic tog_meta_ff;
  logic tog_s_ff;
  logic tog_d_ff;
  logic bit_meta_ff;
  logic bit_s_ff;
  logic bit_hold_ff;
  logic bit_vld_ff;

  wire tog_edge = tog_s_ff ^ tog_d_ff;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tog_meta_ff <= 1'b0;
      tog_s_ff    <= 1'b0;
      tog_d_ff    <= 1'b0;
    end else begin
      tog_meta_ff <= mon_tog_ff;
      tog_s_ff    <= tog_meta_ff;
      tog_d_ff    <= tog_s_ff;
    end
  end

  // Data passes two flops beside its toggle; both leave one link edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bit_meta_ff <= 1'b0;
      bit_s_ff    <= 1'b0;
      bit_hold_ff <= 1'b0;
      bit_vld_ff  <= 1'b0;
    end else begin
      bit_meta_ff <= mon_in_ff;
      bit_s_ff    <= bit_meta_ff;
      bit_vld_ff  <= tog_edge;
      if (tog_edge) begin
        bit_hold_ff <= bit_s_ff;
      end
    end
  end

  assign mode                      = mode_ff;
  assign core_hold                 = core_hold_ff;
  assign shared_io_pin_free        = io_free_ff;
  assign limits                    = limits_ff;
  assign single_supply_prog_enable = ssp_en_ff;
  assign debug_enable              = dbg_en_ff;
  assign erase_go                  = erase_go_ff;
  assign erase_reject              = erase_rej_ff;
  assign fuse_wr_reject            = fuse_rej_ff;
  assign link_bit_valid            = bit_vld_ff;
  assign link_bit                  = bit_hold_ff;
  assign monitor_pin_second_out    = mon_out_ff;
  assign monitor_pin_second_oe     = mon_oe_ff;
  // Monitor clock pin is the link clock itself, not read as data
  wire unused_mon_first = monitor_pin_first;
endmodule

//--- dv/pme_assertions.sv
// Checker for program mode entry control
`timescale 1ns/10ps
module pme_assertions
  import pme_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        prog_entry_pin,
  input wire logic        high_entry_voltage,
  input wire logic        fuse_valid,
  input wire logic        fuse_ssp_wr,
  input wire logic        erase_req,
  input wire pme_erase_t  erase_kind,
  input wire pme_mode_t   mode,
  input wire pme_limits_t limits,
  input wire logic        shared_io_pin_free,
  input wire logic        single_supply_prog_enable,
  input wire logic        debug_enable,
  input wire logic        erase_go,
  input wire logic        erase_reject,
  input wire logic        fuse_wr_reject
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_dbg_fuse: assert property (mode == PME_DEBUG |-> debug_enable)
    else $error("debug mode while disabled");
  a_dbg_limits: assert property (debug_enable |->
    limits == {1'b1, STACK_USER_DBG, PROG_USER_DBG, DATA_USER_DBG})
    else $error("debug reservation wrong");
  a_ssp_gate: assert property (mode == PME_SSP_PROG |-> single_supply_prog_enable)
    else $error("single supply entry while fuse clear");
  a_pin_owner: assert property (single_supply_prog_enable |-> !shared_io_pin_free)
    else $error("entry pin freed while dedicated");
  a_pin_free: assert property ($fell(single_supply_prog_enable) |-> shared_io_pin_free)
    else $error("entry pin not freed");
  a_hv_entry: assert property ((high_entry_voltage && fuse_valid)[*5] |->
    mode == PME_HV_PROG) else $error("high voltage entry missed");
  a_fuse_gate: assert property (fuse_ssp_wr && mode != PME_HV_PROG |=> fuse_wr_reject)
    else $error("fuse write outside high voltage session");
  a_erase_block: assert property (erase_req && erase_kind == ERASE_BLOCK &&
    mode inside {PME_SSP_PROG, PME_HV_PROG} |=> erase_go) else $error("block erase lost");
  a_erase_idle: assert property (erase_req && mode == PME_RUN |=>
    erase_reject && !erase_go) else $error("erase accepted while running");
  a_entry_sync: assert property ($rose(prog_entry_pin) && mode == PME_RUN &&
    !high_entry_voltage |=> mode == PME_RUN) else $error("entry pin acted unsynchronised");
  c_hv: cover property (mode == PME_HV_PROG);
  c_ssp: cover property (mode == PME_SSP_PROG);
  c_dbg: cover property (mode == PME_DEBUG);
endmodule
bind pme_entry_ctrl pme_assertions u_chk (.clk_sys, .rst, .prog_entry_pin,
  .high_entry_voltage, .fuse_valid, .fuse_ssp_wr, .erase_req, .erase_kind, .mode, .limits,
  .shared_io_pin_free, .single_supply_prog_enable, .debug_enable, .erase_go,
  .erase_reject, .fuse_wr_reject);

//--- dv/pme_pod.sv
// Programmer and debugger pod model
`timescale 1ns/10ps
module pme_pod (
  input  wire logic clk_sys,
  output logic      clk_link,
  output logic      monitor_pin_second_in,
  output logic      prog_entry_pin,
  output logic      master_clear_pin,
  output logic      high_entry_voltage
);
  initial begin
    clk_link = 1'b0;
    monitor_pin_second_in = 1'b0;
    prog_entry_pin = 1'b0;
    master_clear_pin = 1'b1;
    high_entry_voltage = 1'b0;
  end
  // Link clock only runs inside frames, reset bursts or single edges the bench asks for
  task automatic clocks(input int n);
    repeat (2 * n) #7.5 clk_link = ~clk_link;
  endtask
  task automatic send(input logic [3:0] b);
    #1.3;
    // Two lead-in edges carry no data; link reset and enable settle
    clocks(2);
    for (int i = 3; i >= 0; i--) begin
      monitor_pin_second_in = b[i];
      #7.5 clk_link = 1'b1;
      #7.5 clk_link = 1'b0;
    end
    // Released line must not keep the last bit
    monitor_pin_second_in = ~b[0];
  endtask
  task automatic mode_pins(input logic hv, input logic ent);
    @(posedge clk_sys);
    high_entry_voltage <= hv;
    prog_entry_pin <= ent;
  endtask
endmodule

//--- dv/tb.sv
// Self-checking bench for program mode entry control
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module tb
  import pme_pkg::*;
;
  logic        clk_sys = 1'b0, rst = 1'b1, fuse_valid = 1'b0, fuse_blank = 1'b0;
  logic        fuse_ssp_wr = 1'b0, fuse_ssp_wdata = 1'b0, erase_req = 1'b0;
  pme_fuse_t   fuse_in = '0;
  pme_erase_t  erase_kind = ERASE_NONE;
  logic        clk_link, monitor_pin_second_in, prog_entry_pin, master_clear_pin;
  logic        high_entry_voltage, single_supply_prog_enable, debug_enable, core_hold;
  logic        shared_io_pin_free, erase_go, erase_reject, fuse_wr_reject;
  logic        link_bit_valid, link_bit;
  logic        mon_data_oe = 1'b0, monitor_pin_second_out, monitor_pin_second_oe;
  logic [3:0]  rx;
  pme_mode_t   mode;
  pme_limits_t limits;
  int          mismatches = 0, tests_run = 0;
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (link_bit_valid) rx <= {rx[2:0], link_bit};
  pme_pod u_pod (.clk_sys, .clk_link, .monitor_pin_second_in, .prog_entry_pin,
    .master_clear_pin, .high_entry_voltage);
  pme_entry_ctrl u_dut (.clk_sys, .rst, .clk_link, .prog_entry_pin, .master_clear_pin,
    .high_entry_voltage, .fuse_valid, .fuse_blank, .fuse_in, .fuse_ssp_wr, .fuse_ssp_wdata,
    .erase_req, .erase_kind, .monitor_pin_first(clk_link), .monitor_pin_second_in,
    .mon_data_out(1'b1), .mon_data_oe, .monitor_pin_second_out,
    .monitor_pin_second_oe, .mode, .core_hold, .shared_io_pin_free, .limits,
    .single_supply_prog_enable, .debug_enable, .erase_go, .erase_reject, .fuse_wr_reject,
    .link_bit_valid, .link_bit);
  task automatic do_reset(input pme_fuse_t f, input logic blank);
    @(posedge clk_sys) rst <= 1'b1;
    fuse_valid <= 1'b0;
    fuse_in <= f;
    fuse_blank <= blank;
    // Link side needs its own clock edges to take the reset
    fork
      repeat (4) @(posedge clk_sys);
      begin
        #1.3;
        u_pod.clocks(3);
      end
    join
    @(posedge clk_sys) rst <= 1'b0;
    @(posedge clk_sys) fuse_valid <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic pins(input logic h, input logic e, input pme_mode_t m);
    u_pod.mode_pins(h, e);
    repeat (4) @(posedge clk_sys);
    #1 `CHK(mode, m)
  endtask
  task automatic erase(input pme_erase_t k, input logic go);
    @(posedge clk_sys) erase_req <= 1'b1;
    erase_kind <= k;
    @(posedge clk_sys) erase_req <= 1'b0;
    #1 `CHK({erase_go, erase_reject}, {go, !go})
  endtask
  task automatic fuse_wr(input logic d, input logic rej);
    @(posedge clk_sys) fuse_ssp_wr <= 1'b1;
    fuse_ssp_wdata <= d;
    @(posedge clk_sys) fuse_ssp_wr <= 1'b0;
    #1 `CHK(fuse_wr_reject, rej)
  endtask
  task automatic t_blank;
    do_reset('0, 1'b1);
    `CHK({single_supply_prog_enable, debug_enable, shared_io_pin_free}, 3'h4)
    erase(ERASE_BLOCK, 1'b0);
    pins(1'b0, 1'b1, PME_SSP_PROG);
    erase(ERASE_ROW, 1'b1);
    fuse_wr(1'b0, 1'b1);
    pins(1'b0, 1'b0, PME_RUN);
    $display("blank part test done");
  endtask
  task automatic t_hv;
    pins(1'b1, 1'b1, PME_HV_PROG);
    `CHK(core_hold, 1'b1)
    fuse_wr(1'b0, 1'b0);
    @(posedge clk_sys);
    #1 `CHK({single_supply_prog_enable, shared_io_pin_free}, 2'h1)
    pins(1'b0, 1'b1, PME_RUN);
    pins(1'b0, 1'b0, PME_RUN);
    $display("high voltage test done");
  endtask
  task automatic t_debug;
    do_reset(3'h1, 1'b0);
    pins(1'b0, 1'b0, PME_DEBUG);
    `CHK(limits, {1'b1, STACK_USER_DBG, PROG_USER_DBG, DATA_USER_DBG})
    u_pod.send(4'hA);
    repeat (6) @(posedge clk_sys);
    #1 `CHK(rx, 4'hA)
    `CHK({monitor_pin_second_oe, monitor_pin_second_out}, 2'h1)
    @(posedge clk_sys) mon_data_oe <= 1'b1;
    u_pod.clocks(1);
    #1 `CHK({monitor_pin_second_oe, monitor_pin_second_out}, 2'h3)
    erase(ERASE_BLOCK, 1'b0);
    pins(1'b1, 1'b0, PME_HV_PROG);
    erase(ERASE_ROW, 1'b0);
    erase(ERASE_BLOCK, 1'b1);
    $display("debug test done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #5000;
    mismatches++;
    wrap_up;
  end
  initial begin
    t_blank;
    t_hv;
    t_debug;
    wrap_up;
  end
endmodule
